// ---- src/uart_mcl_pkg.sv ----
package uart_mcl_pkg;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 6;
  localparam logic [3:0]  IDX_DATA       = 4'h0;
  localparam logic [3:0]  IDX_LINE_CTRL  = 4'h3;
  localparam logic [3:0]  IDX_MODEM_CTRL = 4'h4;
  localparam logic [3:0]  IDX_LINE_STAT  = 4'h5;
  localparam logic [3:0]  IDX_MODEM_STAT = 4'h6;
  localparam logic [3:0]  IDX_INT_STAT   = 4'h8;
  localparam logic [3:0]  IDX_INT_MASK   = 4'h9;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          MC_DTR         = 0;
  localparam int          MC_RTS         = 1;
  localparam int          MC_USER        = 2;
  localparam int          MC_GATE        = 3;
  localparam int          MC_LOOP        = 4;
  localparam int          MC_W           = 5;
  localparam int          LS_RX_READY    = 0;
  localparam int          LS_TX_IDLE     = 5;
  localparam int          INT_RX         = 0;
  localparam int          INT_TX         = 1;
  localparam int          INT_MODEM      = 2;
  localparam int          INT_W          = 3;
  localparam logic [7:0]  LINE_CTRL_RST  = 8'h00;
  localparam logic [4:0]  MODEM_CTRL_RST = 5'h00;
  localparam logic [2:0]  INT_MASK_RST   = 3'h0;
  localparam logic [4:0]  PIN_SYNC_RST   = 5'h1f;

  // ----------------------------------------------------------------
  // Bit timing and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0]  BIT_CYCLES     = 8'h10;
  localparam logic [7:0]  HALF_CYCLES    = 8'h08;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // Modem inputs, active high meaning asserted
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_s;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_e;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_e;

  // Data bits per character from the length code
  function automatic logic [3:0] word_bits(input logic [1:0] len);
    return 4'h5 + {2'b00, len};
  endfunction : word_bits

  // Ones where data bits of the character sit
  function automatic logic [7:0] data_mask(input logic [1:0] len);
    return 8'hff >> (2'h3 - len);
  endfunction : data_mask

  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
    return a[5:2];
  endfunction : reg_index

endpackage : uart_mcl_pkg

// ---- src/pin_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Raw pins and filtered result
  input  wire logic [4:0] pins,
  output logic      [4:0] clean
);

  logic [4:0] stage1;
  logic [4:0] stage2;
  logic [4:0] stage3;

  // Three stages; first one feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= uart_mcl_pkg::PIN_SYNC_RST;
      stage2 <= uart_mcl_pkg::PIN_SYNC_RST;
      stage3 <= uart_mcl_pkg::PIN_SYNC_RST;
    end else begin
      stage1 <= pins;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a bit only once the last two stages agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clean <= uart_mcl_pkg::PIN_SYNC_RST;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (stage2[i] == stage3[i]) begin
          clean[i] <= stage3[i];
        end
      end
    end
  end

endmodule : pin_sync
`default_nettype wire

// ---- src/uart_modem_control_loopback.sv ----
`timescale 1ns/100ps
`default_nettype none
module uart_modem_control_loopback (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [5:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [5:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Serial lines
  input  wire logic        rxd,
  output logic             txd,
  // Modem lines, active low
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ri_n,
  input  wire logic        dcd_n,
  output logic             rts_n,
  output logic             dtr_n,
  // Interrupt pin with enable
  output logic             irq,
  output logic             irq_oe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]                line_ctrl;
  logic [4:0]                modem_ctrl;
  logic [2:0]                int_mask;
  logic [2:0]                int_stat;
  logic [3:0]                ms_delta;
  logic [7:0]                rx_data;
  logic                      rx_ready;
  logic                      aw_held;
  logic                      w_held;
  logic                      next_aw_held;
  logic                      next_w_held;
  logic [5:0]                aw_addr_q;
  logic [7:0]                w_data_q;
  logic                      w_lane0;
  logic                      do_write;
  logic                      wr_en;
  logic [3:0]                wr_idx;
  logic [3:0]                rd_idx;
  logic                      ar_take;
  logic                      rd_data;
  logic                      rd_ms;
  logic                      rd_int;
  logic [7:0]                rd_value;
  logic [4:0]                pins_clean;
  uart_mcl_pkg::modem_s      pin_modem;
  uart_mcl_pkg::modem_s      loop_modem;
  uart_mcl_pkg::modem_s      eff_modem;
  uart_mcl_pkg::modem_s      prev_modem;
  logic [3:0]                ms_change;
  logic                      loop_on;
  uart_mcl_pkg::tx_state_e   tx_state;
  logic                      tx_bit;
  logic [8:0]                tx_shift;
  logic [3:0]                tx_left;
  logic [7:0]                tx_cnt;
  logic                      tx_done;
  logic                      tx_load;
  uart_mcl_pkg::rx_state_e   rx_state;
  logic                      rx_in;
  logic [7:0]                rx_shift;
  logic [3:0]                rx_num;
  logic [7:0]                rx_cnt;
  logic                      rx_done;
  logic [3:0]                wbits;

  // Registers answering on the bus
  function automatic logic is_mapped(input logic [3:0] idx);
    return (idx == uart_mcl_pkg::IDX_DATA) || (idx == uart_mcl_pkg::IDX_LINE_CTRL) ||
           (idx == uart_mcl_pkg::IDX_MODEM_CTRL) || (idx == uart_mcl_pkg::IDX_LINE_STAT) ||
           (idx == uart_mcl_pkg::IDX_MODEM_STAT) || (idx == uart_mcl_pkg::IDX_INT_STAT) ||
           (idx == uart_mcl_pkg::IDX_INT_MASK);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  // Address and data may arrive in either order
  always_comb begin
    do_write     = aw_held && w_held && !bvalid;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
    end else if (do_write) begin
      next_aw_held = 1'b0;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
    end else if (do_write) begin
      next_w_held = 1'b0;
    end
  end

  assign wr_idx = uart_mcl_pkg::reg_index(aw_addr_q);
  assign wr_en  = do_write && w_lane0;

  // Hold address and data until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      aw_addr_q <= 6'h00;
      w_data_q  <= 8'h00;
      w_lane0   <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awready <= !next_aw_held;
      wready  <= !next_w_held;
      if (awvalid && awready) begin
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_data_q <= wdata[7:0];
        w_lane0  <= wstrb[0];
      end
    end
  end

  // Response once both halves are taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= uart_mcl_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= is_mapped(wr_idx) ? uart_mcl_pkg::RESP_OKAY : uart_mcl_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign ar_take = arvalid && arready;
  assign rd_idx  = uart_mcl_pkg::reg_index(araddr);
  assign rd_data = ar_take && (rd_idx == uart_mcl_pkg::IDX_DATA);
  assign rd_ms   = ar_take && (rd_idx == uart_mcl_pkg::IDX_MODEM_STAT);
  assign rd_int  = ar_take && (rd_idx == uart_mcl_pkg::IDX_INT_STAT);

  // Read value mux; reserved bits read zero
  always_comb begin
    rd_value = 8'h00;
    unique case (rd_idx)
      uart_mcl_pkg::IDX_DATA:       rd_value = rx_data;
      uart_mcl_pkg::IDX_LINE_CTRL:  rd_value = line_ctrl;
      uart_mcl_pkg::IDX_MODEM_CTRL: rd_value = {3'h0, modem_ctrl};
      uart_mcl_pkg::IDX_LINE_STAT: begin
        rd_value[uart_mcl_pkg::LS_RX_READY] = rx_ready;
        rd_value[uart_mcl_pkg::LS_TX_IDLE]  = (tx_state == uart_mcl_pkg::TX_IDLE);
      end
      uart_mcl_pkg::IDX_MODEM_STAT: rd_value = {eff_modem, ms_delta};
      uart_mcl_pkg::IDX_INT_STAT:   rd_value = {5'h00, int_stat};
      uart_mcl_pkg::IDX_INT_MASK:   rd_value = {5'h00, int_mask};
      default:                      rd_value = 8'h00;
    endcase
  end

  // One read in flight; arready drops while data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= uart_mcl_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, rd_value};
      rresp   <= is_mapped(rd_idx) ? uart_mcl_pkg::RESP_OKAY : uart_mcl_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Only the low five modem control bits exist; writes to the rest vanish
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_ctrl  <= uart_mcl_pkg::LINE_CTRL_RST;
      modem_ctrl <= uart_mcl_pkg::MODEM_CTRL_RST;
      int_mask   <= uart_mcl_pkg::INT_MASK_RST;
    end else if (wr_en) begin
      if (wr_idx == uart_mcl_pkg::IDX_LINE_CTRL) begin
        line_ctrl <= w_data_q;
      end
      if (wr_idx == uart_mcl_pkg::IDX_MODEM_CTRL) begin
        modem_ctrl <= w_data_q[uart_mcl_pkg::MC_W-1:0];
      end
      if (wr_idx == uart_mcl_pkg::IDX_INT_MASK) begin
        int_mask <= w_data_q[uart_mcl_pkg::INT_W-1:0];
      end
    end
  end

  assign loop_on = modem_ctrl[uart_mcl_pkg::MC_LOOP];
  assign wbits   = uart_mcl_pkg::word_bits(line_ctrl[1:0]);

  // ----------------------------------------------------------------
  // Modem lines
  // ----------------------------------------------------------------
  pin_sync u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pins    ({rxd, dcd_n, ri_n, dsr_n, cts_n}),
    .clean   (pins_clean)
  );

  assign pin_modem  = ~pins_clean[3:0];
  // Own outputs looped onto the status inputs
  assign loop_modem = '{dcd: modem_ctrl[uart_mcl_pkg::MC_GATE],
                        ri:  modem_ctrl[uart_mcl_pkg::MC_USER],
                        dsr: modem_ctrl[uart_mcl_pkg::MC_DTR],
                        cts: modem_ctrl[uart_mcl_pkg::MC_RTS]};
  assign eff_modem  = loop_on ? loop_modem : pin_modem;

  // Ring reports only its trailing edge, the rest any change
  assign ms_change = {eff_modem.dcd ^ prev_modem.dcd,
                      prev_modem.ri & ~eff_modem.ri,
                      eff_modem.dsr ^ prev_modem.dsr,
                      eff_modem.cts ^ prev_modem.cts};

  // Deltas stick until read; a new change beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_modem <= '0;
      ms_delta   <= 4'h0;
    end else begin
      prev_modem <= eff_modem;
      ms_delta   <= (ms_delta & {4{!rd_ms}}) | ms_change;
    end
  end

  // Pins are inverted bits, forced idle in loopback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
    end else begin
      rts_n <= loop_on | ~modem_ctrl[uart_mcl_pkg::MC_RTS];
      dtr_n <= loop_on | ~modem_ctrl[uart_mcl_pkg::MC_DTR];
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // Writes while a character is still going out are dropped
  assign tx_load = wr_en && (wr_idx == uart_mcl_pkg::IDX_DATA) && (tx_state == uart_mcl_pkg::TX_IDLE);
  assign tx_done = (tx_state == uart_mcl_pkg::TX_SHIFT) &&
                   (tx_cnt == uart_mcl_pkg::BIT_CYCLES - 8'h01) && (tx_left == 4'h0);

  // Start bit, data bits, one stop bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= uart_mcl_pkg::TX_IDLE;
      tx_bit   <= 1'b1;
      tx_shift <= 9'h1ff;
      tx_left  <= 4'h0;
      tx_cnt   <= 8'h00;
    end else begin
      unique case (tx_state)
        uart_mcl_pkg::TX_IDLE: begin
          if (tx_load) begin
            tx_state <= uart_mcl_pkg::TX_SHIFT;
            tx_bit   <= 1'b0;
            tx_shift <= {1'b1, w_data_q | ~uart_mcl_pkg::data_mask(line_ctrl[1:0])};
            tx_left  <= wbits + 4'h1;
            tx_cnt   <= 8'h00;
          end
        end
        uart_mcl_pkg::TX_SHIFT: begin
          if (tx_cnt != uart_mcl_pkg::BIT_CYCLES - 8'h01) begin
            tx_cnt <= tx_cnt + 8'h01;
          end else if (tx_left != 4'h0) begin
            tx_cnt   <= 8'h00;
            tx_bit   <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[8:1]};
            tx_left  <= tx_left - 4'h1;
          end else begin
            tx_state <= uart_mcl_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  // Pin sits at mark in loopback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd <= 1'b1;
    end else begin
      txd <= loop_on | tx_bit;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // Loopback takes the shifter output and drops the pin
  assign rx_in   = loop_on ? tx_bit : pins_clean[4];
  assign rx_done = (rx_state == uart_mcl_pkg::RX_STOP) && (rx_cnt == uart_mcl_pkg::BIT_CYCLES - 8'h01);

  // Mid-bit sampling; a framing fault is not checked here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= uart_mcl_pkg::RX_IDLE;
      rx_shift <= 8'h00;
      rx_num   <= 4'h0;
      rx_cnt   <= 8'h00;
    end else begin
      unique case (rx_state)
        uart_mcl_pkg::RX_IDLE: begin
          rx_cnt <= 8'h00;
          if (!rx_in) begin
            rx_state <= uart_mcl_pkg::RX_START;
          end
        end
        uart_mcl_pkg::RX_START: begin
          rx_cnt <= rx_cnt + 8'h01;
          if (rx_cnt == uart_mcl_pkg::HALF_CYCLES - 8'h01) begin
            rx_cnt   <= 8'h00;
            rx_num   <= 4'h0;
            rx_state <= rx_in ? uart_mcl_pkg::RX_IDLE : uart_mcl_pkg::RX_DATA;
          end
        end
        uart_mcl_pkg::RX_DATA: begin
          rx_cnt <= rx_cnt + 8'h01;
          if (rx_cnt == uart_mcl_pkg::BIT_CYCLES - 8'h01) begin
            rx_cnt   <= 8'h00;
            rx_shift <= {rx_in, rx_shift[7:1]};
            rx_num   <= rx_num + 4'h1;
            if (rx_num == wbits - 4'h1) begin
              rx_state <= uart_mcl_pkg::RX_STOP;
            end
          end
        end
        uart_mcl_pkg::RX_STOP: begin
          rx_cnt <= rx_cnt + 8'h01;
          if (rx_done) begin
            rx_state <= uart_mcl_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // Character kept right-aligned; a new one beats the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data  <= 8'h00;
      rx_ready <= 1'b0;
    end else if (rx_done) begin
      rx_data  <= rx_shift >> (4'h8 - wbits);
      rx_ready <= 1'b1;
    end else if (rd_data) begin
      rx_ready <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Sticky events, cleared by reading; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat <= 3'h0;
    end else begin
      int_stat <= (int_stat & {3{!rd_int}}) |
                  {|ms_change, tx_done, rx_done};
    end
  end

  // Gate bit decides whether the pin is driven at all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq    <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      irq_oe <= modem_ctrl[uart_mcl_pkg::MC_GATE];
      irq    <= modem_ctrl[uart_mcl_pkg::MC_GATE] & |(int_stat & int_mask);
    end
  end

endmodule : uart_modem_control_loopback
`default_nettype wire

// ---- test/uart_mcl_properties.sv ----
`timescale 1ns/100ps
`default_nettype none
module uart_mcl_properties (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // Modem and interrupt pins
  input wire logic        rts_n,
  input wire logic        dtr_n,
  input wire logic        irq,
  input wire logic        irq_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h0)
    else $error("read answer missing");
  AST_WRITE_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer missing");
  AST_RDATA_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_BRESP_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  AST_BRESP_CODE: assert property (bvalid |-> bresp == 2'h0 || bresp == 2'h2)
    else $error("bad write code");
  // ----------------------------------------
  // Pins move only after a register write
  // ----------------------------------------
  AST_RTS_CAUSE: assert property ($changed(rts_n) |-> bvalid || $past(bvalid) || $past(bvalid, 2))
    else $error("send request pin moved alone");
  AST_DTR_CAUSE: assert property ($changed(dtr_n) |-> bvalid || $past(bvalid) || $past(bvalid, 2))
    else $error("terminal ready pin moved alone");
  AST_OE_CAUSE: assert property ($changed(irq_oe) |-> bvalid || $past(bvalid) || $past(bvalid, 2))
    else $error("interrupt enable moved alone");
  // Gate low must never let the line assert
  AST_IRQ_GATED: assert property (!irq_oe |-> !irq)
    else $error("interrupt while gated");
endmodule : uart_mcl_properties
`default_nettype wire

// ---- test/modem_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
module modem_partner (
  // Clock and port transmit line
  input  wire logic       aclk,
  input  wire logic       txd,
  // Lines toward the port, idle high
  output logic            rxd,
  output logic      [3:0] mdm_n
);
  initial begin
    rxd = 1'b1;
    mdm_n = 4'hf;
  end
  // Static levels, used to prove inputs are cut off
  task automatic line(input logic v, input logic [3:0] m);
    @(posedge aclk);
    rxd <= v;
    mdm_n <= m;
  endtask : line
  // Frame LSB first, one stop bit, 16 cycles a bit
  task automatic send(input logic [7:0] d, input int n);
    @(posedge aclk);
    rxd <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      repeat (16) @(posedge aclk);
      rxd <= (i == n) ? 1'b1 : d[i];
    end
    repeat (16) @(posedge aclk);
  endtask : send
  // Mid-bit sampling; start may be seen a few cycles late
  task automatic recv(input int n, output logic [7:0] d);
    int k = 0;
    d = 8'h00;
    while (txd && k < 400) begin
      @(posedge aclk);
      k++;
    end
    repeat (8) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge aclk);
      d[i] = txd;
    end
    repeat (24) @(posedge aclk);
  endtask : recv
endmodule : modem_partner
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [5:0] A_DATA = {uart_mcl_pkg::IDX_DATA, 2'b00};
  localparam logic [5:0] A_LC   = {uart_mcl_pkg::IDX_LINE_CTRL, 2'b00};
  localparam logic [5:0] A_MC   = {uart_mcl_pkg::IDX_MODEM_CTRL, 2'b00};
  localparam logic [5:0] A_MS   = {uart_mcl_pkg::IDX_MODEM_STAT, 2'b00};
  localparam logic [5:0] A_IS   = {uart_mcl_pkg::IDX_INT_STAT, 2'b00};
  localparam logic [5:0] A_IM   = {uart_mcl_pkg::IDX_INT_MASK, 2'b00};
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready, rxd;
  logic        awready, wready, bvalid, arready, rvalid, txd, rts_n, dtr_n, irq, irq_oe;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, mdm_n;
  logic [1:0]  bresp, rresp;
  int          fail_count, comparisons, ready_lag;

  always #25 aclk = ~aclk;

  uart_modem_control_loopback dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .rxd, .txd, .cts_n(mdm_n[0]), .dsr_n(mdm_n[1]), .ri_n(mdm_n[2]), .dcd_n(mdm_n[3]),
    .rts_n, .dtr_n, .irq, .irq_oe);
  modem_partner partner_u (.aclk, .txd, .rxd, .mdm_n);

  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // ----------------------------------------
  // Bus master, one transfer at a time
  // ----------------------------------------
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (ready_lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (n == ready_lag) bready <= 1'b1;
    end while (!(bvalid && bready) && n < 200);
    bready <= 1'b0;
    chk({n < 200, bresp}, {1'b1, er});
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [33:0] v);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (ready_lag == 0);
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (n == ready_lag) rready <= 1'b1;
    end while (!(rvalid && rready) && n < 200);
    v = {rresp, rdata};
    rready <= 1'b0;
    if (n >= 200) fail_count++;
  endtask : rd
  // Read with expected response code in bits 33:32
  task automatic rdc(input logic [5:0] a, input logic [33:0] e);
    logic [33:0] v;
    rd(a, v);
    chk(v, e);
  endtask : rdc
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_pins;
    chk({txd, rts_n, dtr_n, irq_oe, irq}, 5'b11100);
    rdc(A_MC, 34'h0);
    ready_lag = 3; // Late ready keeps both answers standing
    wr(A_MC, 32'hef, 2'h0);
    rdc(A_MC, 34'h0f);
    ready_lag = 0;
    chk({rts_n, dtr_n, irq_oe}, 3'b001);
    wr(A_MC, 32'h06, 2'h0);
    repeat (2) @(posedge aclk);
    chk({rts_n, dtr_n, irq_oe, irq}, 4'b0100);
    wr(A_MC, 32'h05, 2'h0);
    repeat (2) @(posedge aclk);
    chk({rts_n, dtr_n, irq_oe, txd}, 4'b1001);
    // Lane zero strobe off, the write must vanish
    wstrb <= 4'h0;
    wr(A_MC, 32'h1f, 2'h0);
    wstrb <= 4'hf;
    rdc(A_MC, 34'h05);
  endtask : t_pins
  // Every length code, both directions
  task automatic t_length;
    logic [7:0] got;
    logic [7:0] m;
    for (int len = 0; len < 4; len++) begin
      m = 8'hff >> (3 - len);
      wr(A_LC, len, 2'h0);
      wr(A_DATA, 32'ha5, 2'h0);
      partner_u.recv(5 + len, got);
      chk(got, 8'ha5 & m);
      partner_u.send(8'h3c, 5 + len);
      repeat (8) @(posedge aclk);
      rdc(A_DATA, {26'h0, 8'h3c & m});
    end
  endtask : t_length
  // Outside lines held active to show they are cut off
  task automatic t_loop;
    wr(A_MC, 32'h15, 2'h0);
    partner_u.line(1'b0, 4'h0);
    repeat (3) @(posedge aclk);
    chk({txd, rts_n, dtr_n, irq_oe, irq}, 5'b11100);
    rdc(A_MS, 34'h62);
    rdc(A_MS, 34'h60);
    wr(A_DATA, 32'h5a, 2'h0);
    repeat (180) begin
      @(posedge aclk);
      chk(txd, 1'b1);
    end
    rdc(A_DATA, 34'h5a);
    rdc(A_IS, 34'h7);
    wr(A_IM, 32'h4, 2'h0);
    wr(A_MC, 32'h1f, 2'h0);
    repeat (4) @(posedge aclk);
    chk({irq_oe, irq, rts_n, mdm_n}, 7'b1110000);
    rdc(A_IS, 34'h4);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    wr(A_IM, 32'h0, 2'h0);
    wr(A_MC, 32'h1d, 2'h0);
    repeat (4) @(posedge aclk);
    chk({irq_oe, irq}, 2'b10);
    partner_u.line(1'b1, 4'hf);
    wr(A_MC, 32'h00, 2'h0);
    repeat (3) @(posedge aclk);
    chk({irq_oe, irq}, 2'b00);
    rdc(6'h3c, {uart_mcl_pkg::RESP_SLVERR, 32'h0});
    wr(6'h3c, 32'h1, uart_mcl_pkg::RESP_SLVERR);
  endtask : t_loop

  task automatic final_report;
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Main sequence, reset held 10 cycles
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 44'h0;
    wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_pins();
    t_length();
    t_loop();
    final_report();
  end
  // Watchdog, well beyond the roughly 1500 cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    final_report();
  end
endmodule : tb_top
bind uart_modem_control_loopback uart_mcl_properties chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .rts_n, .dtr_n, .irq,
  .irq_oe);
`default_nettype wire
